/* File: hw/ppc_pkg.sv */
// package for the parallel port polarity control block
// assumes a 32-bit classic wishbone master and a single 40 MHz clock
`default_nettype none
package ppc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] PPC_CTRL_OFS = 4'h0;  // parallel_port_control
  localparam logic [3:0] PPC_XFER_OFS = 4'h4;  // transfer request
  localparam logic [3:0] PPC_STAT_OFS = 4'h8;  // transfer status / pin view
  // ==========================================================
  // control field positions
  localparam int PPC_RD_POL_BIT = 0;
  localparam int PPC_WR_POL_BIT = 1;
  localparam int PPC_BE_POL_BIT = 2;
  localparam int PPC_CSP_BIT = 3;
  localparam int PPC_MODE_LO = 8;
  localparam int PPC_CSADDR_BIT = 6;  // chip select pin used as address
  localparam logic [15:0] PPC_CTRL_RST = 16'h0000;
  localparam logic [15:0] PPC_CTRL_MASK = 16'h034F;
  // ==========================================================
  // timing: strobe width in ns and derived cycles at 40 MHz
  localparam int PPC_CLK_HZ = 40_000_000;
  localparam int PPC_STROBE_NS = 100;
  localparam int PPC_STROBE_CYC =
    (PPC_STROBE_NS * (PPC_CLK_HZ / 1_000_000) + 999) / 1000;
  // ==========================================================
  typedef enum logic [1:0] {
    PPC_MODE_SLV0 = 2'b00,
    PPC_MODE_SLV1 = 2'b01,
    PPC_MODE_MST2 = 2'b10,
    PPC_MODE_MST1 = 2'b11
  } ppc_mode_t;
  // logical (active-true) pin request bundle
  typedef struct packed {
    logic cs;
    logic be;
    logic wr;
    logic rd;
  } ppc_pins_t;
endpackage
`default_nettype wire

/* File: hw/ppc_pol.sv */
// polarity mapper: turns active-true requests into pin levels
// assumes requests and control bits are registered upstream
`timescale 1ns/1ps
`default_nettype none
module ppc_pol (
  input wire logic [15:0] ctrl_i,
  input wire ppc_pkg::ppc_pins_t req_i,
  input wire logic addr_bit_i,
  output ppc_pkg::ppc_pins_t pin_o
);
  logic mst1;
  // ==========================================================
  // pin level = request xor (not active-high)
  always_comb begin
    mst1 = ctrl_i[ppc_pkg::PPC_MODE_LO +: 2] == ppc_pkg::PPC_MODE_MST1;
    pin_o.be = req_i.be ~^ ctrl_i[ppc_pkg::PPC_BE_POL_BIT];
    // enable strobe in master mode 1, write strobe otherwise
    pin_o.wr = (mst1 ? req_i.wr | req_i.rd : req_i.wr)
               ~^ ctrl_i[ppc_pkg::PPC_WR_POL_BIT];
    // direction line in master mode 1, read strobe otherwise
    pin_o.rd = req_i.rd ~^ ctrl_i[ppc_pkg::PPC_RD_POL_BIT];
    if (ctrl_i[ppc_pkg::PPC_CSADDR_BIT]) begin
      pin_o.cs = addr_bit_i;
    end else begin
      pin_o.cs = req_i.cs ~^ ctrl_i[ppc_pkg::PPC_CSP_BIT];
    end
  end
endmodule // ppc_pol
`default_nettype wire

/* File: hw/ppc_top.sv */
// parallel port polarity control: wishbone registers, strobe
// sequencer and polarity mapping of the port pins
// assumes a classic wishbone master on clk_i, synchronous inputs
//
// Behaviour
// - chip select pin is high when asserted if bit 3 set, else low
// - byte enable is active high when bit 2 set, else active low
// - modes 00/01/10: write strobe level follows bit 1
// - mode 11: bit 1 sets enable strobe active level
// - modes 00/01/10: read strobe level follows bit 0
// - mode 11: bit 0 sets read/write direction line active level
// - chip select used as address ignores polarity, passes address
// - polarity applies to master chip select out, slave select in
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ppc_top #(
  parameter int STROBE_CYC = ppc_pkg::PPC_STROBE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic slave_chip_select_in_i,
  output logic master_chip_select_out_o,
  output logic byte_enable_line_o,
  output logic write_strobe_line_o,
  output logic read_strobe_line_o
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    PPC_IDLE = 2'b00,
    PPC_STRB = 2'b01,
    PPC_DONE = 2'b10
  } ppc_st_t;
  ppc_st_t st_r, st_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  ppc_pkg::ppc_pins_t req_r, req_nxt, pin_w;
  logic addr_r, addr_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic cs_sel_r, cs_sel_nxt;
  ppc_pkg::ppc_pins_t pout_r;
  logic bus_req, wr_ctrl, wr_xfer, slave_mode, slv_sel;
  // ==========================================================
  // polarity mapping of the active-true requests
  ppc_pol u_pol (
    .ctrl_i(ctrl_r),
    .req_i(req_r),
    .addr_bit_i(addr_r),
    .pin_o(pin_w)
  );
  // ==========================================================
  // bus decode; single-cycle ack, dropped the cycle after
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wr_ctrl = bus_req & wb_we_i & (wb_adr_i == ppc_pkg::PPC_CTRL_OFS);
    wr_xfer = bus_req & wb_we_i & (wb_adr_i == ppc_pkg::PPC_XFER_OFS);
    slave_mode = ~ctrl_r[ppc_pkg::PPC_MODE_LO + 1];
    // slave select input decoded with the same polarity bit
    slv_sel = slave_chip_select_in_i ~^ ctrl_r[ppc_pkg::PPC_CSP_BIT];
  end
  // ==========================================================
  // next state for registers and sequencer
  always_comb begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    cnt_nxt = cnt_r;
    req_nxt = req_r;
    addr_nxt = addr_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    ack_nxt = bus_req;
    dat_nxt = dat_r;
    cs_sel_nxt = slv_sel;
    if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        ctrl_nxt[7:0] = wb_dat_i[7:0] & ppc_pkg::PPC_CTRL_MASK[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_nxt[15:8] = wb_dat_i[15:8] & ppc_pkg::PPC_CTRL_MASK[15:8];
      end
    end
    if (bus_req & ~wb_we_i) begin
      case (wb_adr_i)
        ppc_pkg::PPC_CTRL_OFS: dat_nxt = {16'h0000, ctrl_r};
        ppc_pkg::PPC_STAT_OFS: dat_nxt = {24'h0000_00, 2'b00, cs_sel_r,
          done_r, pout_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
    // done flag: a new completion wins over the clearing write
    if (wr_xfer & wb_sel_i[0]) begin
      done_nxt = 1'b0;
    end
    case (st_r)
      PPC_IDLE: begin
        // lines idle at their inactive levels while nothing runs
        req_nxt = '0;
        busy_nxt = 1'b0;
        if (wr_xfer & wb_sel_i[0] & ~slave_mode & ~busy_r) begin
          // bits: 0 read, 1 write, 2 byte enable, 3 address bit
          req_nxt.cs = 1'b1;
          req_nxt.rd = wb_dat_i[0];
          req_nxt.wr = wb_dat_i[1] & ~wb_dat_i[0];
          req_nxt.be = wb_dat_i[2];
          addr_nxt = wb_dat_i[3];
          cnt_nxt = 8'(STROBE_CYC - 1);
          busy_nxt = 1'b1;
          st_nxt = PPC_STRB;
        end
      end
      PPC_STRB: begin
        if (cnt_r == 8'h00) begin
          // drop the lines here so the strobe lasts exactly STROBE_CYC
          req_nxt = '0;
          st_nxt = PPC_DONE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      PPC_DONE: begin
        req_nxt = '0;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = PPC_IDLE;
      end
      default: st_nxt = PPC_IDLE;
    endcase
  end
  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= PPC_IDLE;
      ctrl_r <= ppc_pkg::PPC_CTRL_RST;
      cnt_r <= 8'h00;
      req_r <= '0;
      addr_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      cs_sel_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      cs_sel_r <= cs_sel_nxt;
    end
  end
  // ==========================================================
  // output pins registered; one cycle behind the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // pins reset to the inactive levels of the reset polarity bits,
      // so no line looks asserted while the port is held in reset
      pout_r <= ~ppc_pkg::PPC_CTRL_RST[3:0];
    end else begin
      pout_r <= pin_w;
    end
  end
  assign master_chip_select_out_o = pout_r.cs;
  assign byte_enable_line_o = pout_r.be;
  assign write_strobe_line_o = pout_r.wr;
  assign read_strobe_line_o = pout_r.rd;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  // ==========================================================
  // checks
  property cs_pol_p;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_r[ppc_pkg::PPC_CSADDR_BIT] |=>
        master_chip_select_out_o ==
        ($past(req_r.cs) ~^ $past(ctrl_r[ppc_pkg::PPC_CSP_BIT]));
  endproperty
  cs_polarity_a: assert property (cs_pol_p)
    else $error("chip select level wrong");
  be_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> byte_enable_line_o ==
      ($past(req_r.be) ~^ $past(ctrl_r[ppc_pkg::PPC_BE_POL_BIT])))
    else $error("byte enable level wrong");
  wr_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r[9:8] != 2'b11 |=> write_strobe_line_o ==
      ($past(req_r.wr) ~^ $past(ctrl_r[ppc_pkg::PPC_WR_POL_BIT])))
    else $error("write strobe level wrong");
  en_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r[9:8] == 2'b11 |=> write_strobe_line_o ==
      (($past(req_r.wr) | $past(req_r.rd)) ~^
       $past(ctrl_r[ppc_pkg::PPC_WR_POL_BIT])))
    else $error("enable strobe level wrong");
  rd_polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> read_strobe_line_o ==
      ($past(req_r.rd) ~^ $past(ctrl_r[ppc_pkg::PPC_RD_POL_BIT])))
    else $error("read strobe level wrong");
  cs_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r[ppc_pkg::PPC_CSADDR_BIT] |=>
      master_chip_select_out_o == $past(addr_r))
    else $error("address pin altered");
  slv_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> cs_sel_r == ($past(slave_chip_select_in_i) ~^
      $past(ctrl_r[ppc_pkg::PPC_CSP_BIT])))
    else $error("slave select decode wrong");
  sequence idle_s;
    st_r == PPC_IDLE && !busy_r;
  endsequence
  idle_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_s ##1 idle_s |-> req_r == 4'b0000)
    else $error("lines not idle");
endmodule // ppc_top
`default_nettype wire

/* File: testbench/ppc_peer.sv */
// far-side model: host that drives the slave chip select pin
// assumes the bench says when the host owns the line
`timescale 1ns/1ps
`default_nettype none
module ppc_peer (
  input wire logic clk_i,
  input wire logic drive_en_i,
  input wire logic level_i,
  output logic chip_select_o
);
  // ==========================================================
  // released line toggles so a stale level can never pass
  logic last_r = 1'b0;
  always_ff @(posedge clk_i) begin
    last_r <= drive_en_i ? level_i : ~last_r;
  end
  assign chip_select_o = last_r;
endmodule // ppc_peer
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the polarity control block
// assumes a classic wishbone slave answering with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, h_en = 1'b0, h_lvl = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, q;
  logic [31:0] rdat;
  logic ack, s_cs, cs, be, wr, rd;
  int n_errors = 0, n_checks = 0;
  logic a_q = 1'b0;  // address value last accepted by a transfer
  wire logic [3:0] pins = {cs, be, wr, rd};
  always #12.5 clk_i = ~clk_i;
  ppc_top #(.STROBE_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .slave_chip_select_in_i(s_cs), .master_chip_select_out_o(cs),
    .byte_enable_line_o(be), .write_strobe_line_o(wr),
    .read_strobe_line_o(rd));
  ppc_peer u_peer (.clk_i(clk_i), .drive_en_i(h_en), .level_i(h_lvl),
    .chip_select_o(s_cs));
  // ==========================================================
  // verdict, reached from the main flow, the bus ack timeout and the global timeout
  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle: request held until ack is seen at a rising edge,
  // read data taken at that same edge, then released for a cycle
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      summarize();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // ==========================================================
  // one master transfer: idle levels, active levels, strobe width
  task automatic xfer(input logic [1:0] m, input logic [3:0] p,
                      input logic w, input logic csa, input logic a);
    int i;
    logic [3:0] msk, act, idl;
    msk = (m == 2'b11) ? 4'he : 4'hf;  // direction idle level undefined
    act = {csa ? a : p[3], p[2] ^ ~w, p[1] ^ ~(w | m[0]), p[0] ^ w};
    // an address pin keeps the last accepted address while idle
    idl = {csa ? a_q : ~p[3], ~p[2:0]} & msk;
    bus(1'b1, ppc_pkg::PPC_CTRL_OFS, {22'h0, m, 1'b0, csa, 2'b00, p});
    repeat (2) @(negedge clk_i);
    chk({28'h0, pins & msk}, {28'h0, idl});
    bus(1'b1, ppc_pkg::PPC_XFER_OFS, {28'h0, a, w, w, ~w});
    for (i = 0; i < 20 && pins !== act; i++) @(negedge clk_i);
    chk({28'h0, pins}, {28'h0, act});
    for (i = 0; i < 20 && pins === act; i++) @(negedge clk_i);
    chk(i, 4);
    a_q = a;
    idl = {csa ? a_q : ~p[3], ~p[2:0]} & msk;
    chk({28'h0, pins & msk}, {28'h0, idl});
    bus(1'b0, ppc_pkg::PPC_STAT_OFS, 32'h0000_0000);
    chk({31'h0, q[4]}, 32'h0000_0001);
  endtask
  // slave modes: transfer refused, chip select input decoded
  task automatic slave(input logic [1:0] m, input logic [3:0] p);
    bus(1'b1, ppc_pkg::PPC_CTRL_OFS, {22'h0, m, 4'h0, p});
    bus(1'b1, ppc_pkg::PPC_XFER_OFS, 32'h0000_0002);
    repeat (10) @(negedge clk_i);
    chk({28'h0, pins}, {28'h0, ~p});
    for (int l = 0; l < 2; l++) begin
      @(posedge clk_i);
      h_en <= 1'b1; h_lvl <= l[0];
      repeat (3) @(posedge clk_i);
      bus(1'b0, ppc_pkg::PPC_STAT_OFS, 32'h0000_0000);
      chk({31'h0, q[5]}, {31'h0, l[0] == p[3]});
    end
    @(posedge clk_i);
    h_en <= 1'b0;
  endtask
  // ==========================================================
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, ppc_pkg::PPC_CTRL_OFS, 32'h0000_0000);
    chk(q, {16'h0, ppc_pkg::PPC_CTRL_RST});
    chk({28'h0, pins}, 32'h0000_000f);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b1, ppc_pkg::PPC_CTRL_OFS, 32'hffff_ffff);
    bus(1'b0, ppc_pkg::PPC_CTRL_OFS, 32'h0000_0000);
    chk(q, {16'h0, ppc_pkg::PPC_CTRL_MASK});
    for (int k = 0; k < 16; k++) begin
      xfer({1'b1, k[3]}, {k[0], ~k[0], k[1], k[1] ^ k[0]}, k[2], 1'b0,
           1'b0);
    end
    xfer(2'b10, 4'h8, 1'b1, 1'b1, 1'b0);
    xfer(2'b11, 4'h0, 1'b0, 1'b1, 1'b1);
    slave(2'b00, 4'h8);
    slave(2'b01, 4'h3);
    summarize();
  end
  initial begin
    #500000;
    n_errors++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
